// ### pin_change_defines.vh
// register map, field positions and reset values of the pin-change edge interrupt block
`ifndef PIN_CHANGE_DEFINES_VH
`define PIN_CHANGE_DEFINES_VH

// register indices on the plain register port
`define ADDR_W            4
`define ADDR_A_RISE       4'h0
`define ADDR_A_FALL       4'h1
`define ADDR_A_FLAGS      4'h2
`define ADDR_B_RISE       4'h3
`define ADDR_B_FALL       4'h4
`define ADDR_B_FLAGS      4'h5
`define ADDR_C_RISE       4'h6
`define ADDR_C_FALL       4'h7
`define ADDR_C_FLAGS      4'h8
`define ADDR_E_RISE       4'h9
`define ADDR_E_FALL       4'hA
`define ADDR_E_FLAGS      4'hB
`define ADDR_IRQ_ENABLE   4'hC
`define ADDR_IRQ_REQUEST  4'hD

// field positions
`define MASTER_EN_BIT     0
`define SUMMARY_BIT       0
`define PORT_E_PIN        3

// reset values and masks
`define REG_RESET         8'h00
`define PORT_E_MASK       8'h08
`define READ_ZERO         8'h00

`endif

// ### pin_change_edge_interrupt.v
// pin-change edge detection, per-pin flags, summary flag, interrupt and wake request
//
// Notes on behaviour
// R1: interrupt output rises only while the master change enable bit is set.
// R2: with master enable clear, edges still set flags but no interrupt.
// R3: every change-capable pin has its own rising and falling detector.
// R4: rise enable bit 1 enables rising detection on its pin, 0 disables.
// R5: fall enable bit 1 enables falling detection on its pin, 0 disables.
// R6: both enables set detects edges of either polarity.
// R7: flag sets on enabled rising or enabled falling edge of its pin.
// R8: summary flag is OR of all per-pin flags and is read-only.
// R9: software clears any single flag by writing zero to it.
// R10: edge seen during a flag write leaves that flag set afterwards.
// R11: software clears flags with AND masking only bits it saw set.
// R12: enabled edge wakes device from sleep when master enable is set.
// R13: edges during sleep are recorded in flags on the same clock edge the wake request rises.
// R14: flags set only by hardware, cleared only by software; zero means none.
// R15: master-clear or low-voltage program enable removes port E pin 3 detection.
// R16: ports A, B, C all eight pins; port E only bit 3, others read zero.
// R17: each pin synchronised by two flops, edge from current versus previous sample.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "pin_change_defines.vh"

module pin_change_edge_interrupt (
  // clock and reset
  input  wire                 sys_clk,
  input  wire                 srst,
  // register port
  input  wire [`ADDR_W-1:0]   reg_addr,
  input  wire [7:0]           reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [7:0]           reg_rdata,
  // port pins
  input  wire [7:0]           port_a_pins,
  input  wire [7:0]           port_b_pins,
  input  wire [7:0]           port_c_pins,
  input  wire                 port_e_pin3,
  // configuration levels
  input  wire                 master_clear_pin_enable,
  input  wire                 low_voltage_program_enable,
  // system status and requests
  input  wire                 sleep_active,
  output reg                  change_irq,
  output reg                  wake_request
);

  // ==========================================================
  // helper functions

  // next flag value: hardware set wins over a software clear
  function [7:0] next_flags;
    input [7:0] cur;
    input [7:0] edges;
    input       wr_hit;
    input [7:0] wdata;
    begin
      if (wr_hit) begin
        next_flags = (cur & wdata) | edges; // see R9, see R10, see R11
      end else begin
        next_flags = cur | edges; // see R14
      end
    end
  endfunction

  // enabled edges from current and previous samples
  function [7:0] detect;
    input [7:0] cur;
    input [7:0] prev;
    input [7:0] rise_en;
    input [7:0] fall_en;
    begin
      // independent detectors per pin, either polarity when both set
      detect = (cur & ~prev & rise_en) | (~cur & prev & fall_en); // see R3, see R4, see R5, see R6
    end
  endfunction

  // one when any flag of any port is set
  function any_flag;
    input [7:0] a_f;
    input [7:0] b_f;
    input [7:0] c_f;
    input [7:0] e_f;
    begin
      any_flag = |{a_f, b_f, c_f, e_f}; // see R8
    end
  endfunction

  // ==========================================================
  // registers

  reg [7:0] port_a_rise_enable_r;
  reg [7:0] port_a_fall_enable_r;
  reg [7:0] port_a_change_flags_r;
  reg [7:0] port_b_rise_enable_r;
  reg [7:0] port_b_fall_enable_r;
  reg [7:0] port_b_change_flags_r;
  reg [7:0] port_c_rise_enable_r;
  reg [7:0] port_c_fall_enable_r;
  reg [7:0] port_c_change_flags_r;
  reg [7:0] port_e_rise_enable_r;
  reg [7:0] port_e_fall_enable_r;
  reg [7:0] port_e_change_flags_r;
  reg       change_irq_master_enable_r;

  // synchronisers: first stage read only by second stage
  reg [7:0] a_meta_r;
  reg [7:0] a_sync_r;
  reg [7:0] a_prev_r;
  reg [7:0] b_meta_r;
  reg [7:0] b_sync_r;
  reg [7:0] b_prev_r;
  reg [7:0] c_meta_r;
  reg [7:0] c_sync_r;
  reg [7:0] c_prev_r;
  reg       e_meta_r;
  reg       e_sync_r;
  reg       e_prev_r;
  reg       mclr_meta_r;
  reg       mclr_sync_r;
  reg       lowv_meta_r;
  reg       lowv_sync_r;
  reg       sleep_meta_r;
  reg       sleep_sync_r;

  // ==========================================================
  // edge detection

  wire       e_disabled;
  wire [7:0] e_cur;
  wire [7:0] e_prev;
  wire [7:0] a_edges;
  wire [7:0] b_edges;
  wire [7:0] c_edges;
  wire [7:0] e_edges;
  wire [7:0] a_flags_nxt;
  wire [7:0] b_flags_nxt;
  wire [7:0] c_flags_nxt;
  wire [7:0] e_flags_nxt;
  wire       summary_nxt;

  // port E pin is lost to port use when either configuration is set
  assign e_disabled = mclr_sync_r | lowv_sync_r; // see R15
  assign e_cur      = {4'h0, e_sync_r, 3'h0};
  assign e_prev     = {4'h0, e_prev_r, 3'h0};

  assign a_edges = detect(a_sync_r, a_prev_r, port_a_rise_enable_r, port_a_fall_enable_r); // see R7
  assign b_edges = detect(b_sync_r, b_prev_r, port_b_rise_enable_r, port_b_fall_enable_r); // see R7
  assign c_edges = detect(c_sync_r, c_prev_r, port_c_rise_enable_r, port_c_fall_enable_r); // see R7
  // only bit 3 of port E can report
  assign e_edges = detect(e_cur, e_prev, port_e_rise_enable_r, port_e_fall_enable_r)
                   & (e_disabled ? `READ_ZERO : `PORT_E_MASK); // see R15, see R16

  assign a_flags_nxt = next_flags(port_a_change_flags_r, a_edges,
                                  reg_wr && (reg_addr == `ADDR_A_FLAGS), reg_wdata);
  assign b_flags_nxt = next_flags(port_b_change_flags_r, b_edges,
                                  reg_wr && (reg_addr == `ADDR_B_FLAGS), reg_wdata);
  assign c_flags_nxt = next_flags(port_c_change_flags_r, c_edges,
                                  reg_wr && (reg_addr == `ADDR_C_FLAGS), reg_wdata);
  assign e_flags_nxt = next_flags(port_e_change_flags_r, e_edges,
                                  reg_wr && (reg_addr == `ADDR_E_FLAGS), reg_wdata)
                       & `PORT_E_MASK; // see R16

  // summary of every flag in every port
  assign summary_nxt = any_flag(a_flags_nxt, b_flags_nxt, c_flags_nxt, e_flags_nxt); // see R8

  // ==========================================================
  // input synchronisers and previous samples

  // two flops per pin, then a previous sample for comparison
  always @(posedge sys_clk) begin
    if (srst) begin
      a_meta_r     <= `REG_RESET;
      a_sync_r     <= `REG_RESET;
      a_prev_r     <= `REG_RESET;
      b_meta_r     <= `REG_RESET;
      b_sync_r     <= `REG_RESET;
      b_prev_r     <= `REG_RESET;
      c_meta_r     <= `REG_RESET;
      c_sync_r     <= `REG_RESET;
      c_prev_r     <= `REG_RESET;
      e_meta_r     <= 1'b0;
      e_sync_r     <= 1'b0;
      e_prev_r     <= 1'b0;
      mclr_meta_r  <= 1'b0;
      mclr_sync_r  <= 1'b0;
      lowv_meta_r  <= 1'b0;
      lowv_sync_r  <= 1'b0;
      sleep_meta_r <= 1'b0;
      sleep_sync_r <= 1'b0;
    end else begin
      a_meta_r     <= port_a_pins;
      a_sync_r     <= a_meta_r;
      a_prev_r     <= a_sync_r; // see R17
      b_meta_r     <= port_b_pins;
      b_sync_r     <= b_meta_r;
      b_prev_r     <= b_sync_r; // see R17
      c_meta_r     <= port_c_pins;
      c_sync_r     <= c_meta_r;
      c_prev_r     <= c_sync_r; // see R17
      e_meta_r     <= port_e_pin3;
      e_sync_r     <= e_meta_r;
      e_prev_r     <= e_sync_r; // see R17
      mclr_meta_r  <= master_clear_pin_enable;
      mclr_sync_r  <= mclr_meta_r;
      lowv_meta_r  <= low_voltage_program_enable;
      lowv_sync_r  <= lowv_meta_r;
      sleep_meta_r <= sleep_active;
      sleep_sync_r <= sleep_meta_r;
    end
  end

  // ==========================================================
  // register writes and flag update

  // enables store on write; flags update every cycle
  always @(posedge sys_clk) begin
    if (srst) begin
      port_a_rise_enable_r       <= `REG_RESET;
      port_a_fall_enable_r       <= `REG_RESET;
      port_a_change_flags_r      <= `REG_RESET;
      port_b_rise_enable_r       <= `REG_RESET;
      port_b_fall_enable_r       <= `REG_RESET;
      port_b_change_flags_r      <= `REG_RESET;
      port_c_rise_enable_r       <= `REG_RESET;
      port_c_fall_enable_r       <= `REG_RESET;
      port_c_change_flags_r      <= `REG_RESET;
      port_e_rise_enable_r       <= `REG_RESET;
      port_e_fall_enable_r       <= `REG_RESET;
      port_e_change_flags_r      <= `REG_RESET;
      change_irq_master_enable_r <= 1'b0;
    end else begin
      port_a_change_flags_r <= a_flags_nxt; // see R7
      port_b_change_flags_r <= b_flags_nxt; // see R7
      port_c_change_flags_r <= c_flags_nxt; // see R7
      port_e_change_flags_r <= e_flags_nxt; // see R7
      if (reg_wr) begin
        case (reg_addr)
          `ADDR_A_RISE: begin
            port_a_rise_enable_r <= reg_wdata; // see R4
          end
          `ADDR_A_FALL: begin
            port_a_fall_enable_r <= reg_wdata; // see R5
          end
          `ADDR_B_RISE: begin
            port_b_rise_enable_r <= reg_wdata; // see R4
          end
          `ADDR_B_FALL: begin
            port_b_fall_enable_r <= reg_wdata; // see R5
          end
          `ADDR_C_RISE: begin
            port_c_rise_enable_r <= reg_wdata; // see R4
          end
          `ADDR_C_FALL: begin
            port_c_fall_enable_r <= reg_wdata; // see R5
          end
          `ADDR_E_RISE: begin
            port_e_rise_enable_r <= reg_wdata & `PORT_E_MASK; // see R16
          end
          `ADDR_E_FALL: begin
            port_e_fall_enable_r <= reg_wdata & `PORT_E_MASK; // see R16
          end
          `ADDR_IRQ_ENABLE: begin
            change_irq_master_enable_r <= reg_wdata[`MASTER_EN_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // interrupt and wake outputs

  // flags keep recording regardless; outputs gated by master enable
  always @(posedge sys_clk) begin
    if (srst) begin
      change_irq   <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      change_irq   <= summary_nxt & change_irq_master_enable_r; // see R1, see R2
      // flag is in place the same edge the wake request rises
      wake_request <= summary_nxt & change_irq_master_enable_r & sleep_sync_r; // see R12, see R13
    end
  end

  // ==========================================================
  // register reads

  // read data one cycle after the strobe, zero otherwise
  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= `READ_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_A_RISE: begin
          reg_rdata <= port_a_rise_enable_r;
        end
        `ADDR_A_FALL: begin
          reg_rdata <= port_a_fall_enable_r;
        end
        `ADDR_A_FLAGS: begin
          reg_rdata <= port_a_change_flags_r;
        end
        `ADDR_B_RISE: begin
          reg_rdata <= port_b_rise_enable_r;
        end
        `ADDR_B_FALL: begin
          reg_rdata <= port_b_fall_enable_r;
        end
        `ADDR_B_FLAGS: begin
          reg_rdata <= port_b_change_flags_r;
        end
        `ADDR_C_RISE: begin
          reg_rdata <= port_c_rise_enable_r;
        end
        `ADDR_C_FALL: begin
          reg_rdata <= port_c_fall_enable_r;
        end
        `ADDR_C_FLAGS: begin
          reg_rdata <= port_c_change_flags_r;
        end
        `ADDR_E_RISE: begin
          reg_rdata <= port_e_rise_enable_r;
        end
        `ADDR_E_FALL: begin
          reg_rdata <= port_e_fall_enable_r;
        end
        `ADDR_E_FLAGS: begin
          reg_rdata <= port_e_change_flags_r; // see R16
        end
        `ADDR_IRQ_ENABLE: begin
          reg_rdata <= {7'h00, change_irq_master_enable_r};
        end
        // summary is status only; writes here are ignored
        `ADDR_IRQ_REQUEST: begin
          reg_rdata <= {7'h00, any_flag(port_a_change_flags_r, port_b_change_flags_r,
                                        port_c_change_flags_r, port_e_change_flags_r)}; // see R8
        end
        default: begin
          reg_rdata <= `READ_ZERO;
        end
      endcase
    end else begin
      reg_rdata <= `READ_ZERO;
    end
  end

endmodule

// ### pin_change_monitor.sv
// port checker of the pin-change edge interrupt block
`timescale 1ns/100ps
`include "pin_change_defines.vh"
module pin_change_monitor (
  // clock and reset
  input wire               sys_clk,
  input wire               srst,
  // register port
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [7:0]         reg_wdata,
  input wire               reg_wr,
  input wire               reg_rd,
  input wire [7:0]         reg_rdata,
  // pins and requests
  input wire [7:0]         port_a_pins,
  input wire               sleep_active,
  input wire               change_irq,
  input wire               wake_request
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  reg en_r;
  reg rise_a0_r;
  // ============================================================
  // shadows of the master enable and port A pin 0 rise enable
  always @(posedge sys_clk) begin
    if (srst) begin
      en_r      <= 1'b0;
      rise_a0_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_IRQ_ENABLE) en_r <= reg_wdata[`MASTER_EN_BIT];
      if (reg_addr == `ADDR_A_RISE) rise_a0_r <= reg_wdata[0];
    end
  end
  // ============================================================
  // properties
  property p_irq_needs_enable;
    change_irq |-> $past(en_r);
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable)
    else $error("interrupt while master enable clear");
  property p_wake_needs_irq;
    wake_request |-> change_irq && $past(sleep_active, 3);
  endproperty
  a_wake_needs_irq: assert property (p_wake_needs_irq)
    else $error("wake request without interrupt condition");
  property p_rdata_one_cycle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_one_cycle: assert property (p_rdata_one_cycle)
    else $error("read data outside its cycle");
  property p_unmapped_zero;
    $past(reg_rd) && $past(reg_addr) > `ADDR_IRQ_REQUEST |-> reg_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped index read nonzero");
  property p_port_e_bits;
    $past(reg_rd) && $past(reg_addr) >= `ADDR_E_RISE && $past(reg_addr) <= `ADDR_E_FLAGS
      |-> (reg_rdata & ~`PORT_E_MASK) == 8'h00;
  endproperty
  a_port_e_bits: assert property (p_port_e_bits)
    else $error("port E unimplemented bit read nonzero");
  property p_summary_bit;
    $past(reg_rd) && $past(reg_addr) == `ADDR_IRQ_REQUEST |-> reg_rdata[7:1] == 7'h00;
  endproperty
  a_summary_bit: assert property (p_summary_bit)
    else $error("summary register upper bits set");
  property p_rise_sets_irq;
    $rose(port_a_pins[0]) && en_r && rise_a0_r |-> ##[1:3] change_irq;
  endproperty
  a_rise_sets_irq: assert property (p_rise_sets_irq)
    else $error("enabled rising edge raised no interrupt");
  property p_irq_fall_by_write;
    $fell(change_irq) |-> $past(reg_wr);
  endproperty
  a_irq_fall_by_write: assert property (p_irq_fall_by_write)
    else $error("interrupt dropped without a write");
  // main scenarios
  c_irq: cover property ($rose(change_irq));
  c_wake: cover property ($rose(wake_request));
  c_clear: cover property (reg_wr && reg_addr == `ADDR_A_FLAGS && change_irq);
endmodule

bind pin_change_edge_interrupt pin_change_monitor mon (
  .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_pins(port_a_pins),
  .change_irq(change_irq), .wake_request(wake_request), .sleep_active(sleep_active));

// ### pin_env.sv
// far-side model: pin levels, configuration levels and sleep status
`timescale 1ns/100ps
module pin_env (
  // clock
  input wire       sys_clk,
  // pin levels
  output reg [7:0] port_a_pins,
  output reg [7:0] port_b_pins,
  output reg [7:0] port_c_pins,
  output reg       port_e_pin3,
  // configuration and sleep
  output reg       master_clear_pin_enable,
  output reg       low_voltage_program_enable,
  output reg       sleep_active
);
  // all lines low at time zero
  initial begin
    {port_a_pins, port_b_pins, port_c_pins, port_e_pin3} = 25'h000_0000;
    {master_clear_pin_enable, low_voltage_program_enable, sleep_active} = 3'h0;
  end
  // pins move just after a clock edge
  task set_pins(input [7:0] a, input [7:0] b, input [7:0] c, input e);
    begin
      @(posedge sys_clk);
      port_a_pins <= a;
      port_b_pins <= b;
      port_c_pins <= c;
      port_e_pin3 <= e;
    end
  endtask
  // configuration and sleep levels
  task set_cfg(input m, input l, input s);
    begin
      @(posedge sys_clk);
      master_clear_pin_enable    <= m;
      low_voltage_program_enable <= l;
      sleep_active               <= s;
    end
  endtask
endmodule

// ### tb_pin_change_edge_interrupt.sv
// self-checking bench of the pin-change edge interrupt block
`timescale 1ns/100ps
`include "pin_change_defines.vh"
module tb_pin_change_edge_interrupt;
  reg                sys_clk;
  reg                srst;
  reg  [`ADDR_W-1:0] reg_addr;
  reg  [7:0]         reg_wdata;
  reg                reg_wr;
  reg                reg_rd;
  wire [7:0]         reg_rdata;
  wire [7:0]         pa;
  wire [7:0]         pb;
  wire [7:0]         pc;
  wire               pe;
  wire               mclr;
  wire               lowv;
  wire               slp;
  wire               change_irq;
  wire               wake_request;
  integer            errors;
  integer            comparisons;
  integer            cycles;
  integer            i;
  reg  [7:0]         d;

  pin_change_edge_interrupt uut (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_pins(pa),
    .port_b_pins(pb), .port_c_pins(pc), .port_e_pin3(pe), .master_clear_pin_enable(mclr),
    .low_voltage_program_enable(lowv), .sleep_active(slp), .change_irq(change_irq),
    .wake_request(wake_request));
  pin_env env (
    .sys_clk(sys_clk), .port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc),
    .port_e_pin3(pe), .master_clear_pin_enable(mclr), .low_voltage_program_enable(lowv),
    .sleep_active(slp));

  // ============================================================
  // clock and hang guard
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end

  // ============================================================
  // tasks
  task check(input [8*8:1] name, input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [7:0] v);
    begin
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
    end
  endtask
  task rd_chk(input [3:0] a, input [7:0] exp);
    begin
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
      check("rdata", d, exp);
    end
  endtask
  task settle;
    begin
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // ============================================================
  // main sequence
  initial begin
    {srst, reg_addr, reg_wdata, reg_wr, reg_rd} = 15'h4000;
    {errors, comparisons, cycles} = 96'h0;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    for (i = 0; i < 16; i = i + 1) rd_chk(i[3:0], 8'h00);
    for (i = 0; i < 12; i = i + 1) if (i % 3 != 2) wr_reg(i[3:0], 8'hFF);
    for (i = 0; i < 12; i = i + 1) if (i % 3 != 2) rd_chk(i[3:0], i < 9 ? 8'hFF : 8'h08);
    wr_reg(`ADDR_IRQ_REQUEST, 8'hFF);
    rd_chk(`ADDR_IRQ_REQUEST, 8'h00);
    wr_reg(`ADDR_A_RISE, 8'h0F);
    wr_reg(`ADDR_A_FALL, 8'hF0);
    // rising then falling on port A with master enable clear
    env.set_pins(8'hFF, 8'h00, 8'h00, 1'b0);
    settle;
    rd_chk(`ADDR_A_FLAGS, 8'h0F);
    rd_chk(`ADDR_IRQ_REQUEST, 8'h01);
    check("irq", change_irq, 8'h00);
    wr_reg(`ADDR_A_FLAGS, 8'h00);
    rd_chk(`ADDR_A_FLAGS, 8'h00);
    env.set_pins(8'h00, 8'h00, 8'h00, 1'b0);
    settle;
    rd_chk(`ADDR_A_FLAGS, 8'hF0);
    wr_reg(`ADDR_IRQ_ENABLE, 8'h01);
    // the interrupt register follows the stored enable one cycle later
    repeat (2) @(negedge sys_clk);
    check("irq", change_irq, 8'h01);
    // masked clear while pin 0 rises in between
    rd_chk(`ADDR_A_FLAGS, 8'hF0);
    env.set_pins(8'h01, 8'h00, 8'h00, 1'b0);
    settle;
    wr_reg(`ADDR_A_FLAGS, 8'hFF ^ d);
    rd_chk(`ADDR_A_FLAGS, 8'h01);
    wr_reg(`ADDR_A_FLAGS, 8'h00);
    @(negedge sys_clk);
    check("irq", change_irq, 8'h00);
    // both polarities on port B
    env.set_pins(8'h01, 8'h55, 8'h00, 1'b0);
    settle;
    rd_chk(`ADDR_B_FLAGS, 8'h55);
    wr_reg(`ADDR_B_FLAGS, 8'h00);
    env.set_pins(8'h01, 8'h00, 8'h00, 1'b0);
    settle;
    rd_chk(`ADDR_B_FLAGS, 8'h55);
    wr_reg(`ADDR_B_FLAGS, 8'h00);
    // one clearing write lands on the edge that sets port C pin 7
    env.set_pins(8'h01, 8'h00, 8'h80, 1'b0);
    repeat (2) @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= `ADDR_C_FLAGS;
    reg_wdata <= 8'h00;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    settle;
    rd_chk(`ADDR_C_FLAGS, 8'h80);
    wr_reg(`ADDR_C_FLAGS, 8'h00);
    // edge while asleep wakes the device and is already recorded
    env.set_cfg(1'b0, 1'b0, 1'b1);
    settle;
    env.set_pins(8'h03, 8'h00, 8'h80, 1'b0);
    for (i = 0; i < 10 && wake_request !== 1'b1; i = i + 1) @(negedge sys_clk);
    check("wake", wake_request, 8'h01);
    rd_chk(`ADDR_A_FLAGS, 8'h02);
    env.set_cfg(1'b0, 1'b0, 1'b0);
    wr_reg(`ADDR_A_FLAGS, 8'h00);
    // port E pin 3 blocked by either configuration level
    for (i = 0; i < 3; i = i + 1) begin
      env.set_cfg(i == 0, i == 1, 1'b0);
      settle;
      env.set_pins(8'h03, 8'h00, 8'h80, ~i[0]);
      settle;
      rd_chk(`ADDR_E_FLAGS, i == 2 ? 8'h08 : 8'h00);
    end
    wr_reg(`ADDR_E_FLAGS, 8'h00);
    rd_chk(`ADDR_IRQ_REQUEST, 8'h00);
    check("irq", change_irq, 8'h00);
    tally_and_finish;
  end
endmodule
